//--- special_instr_exec_unit_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module special_instr_exec_unit_tb_top
  import sxu_pkg::*;
;
  // One ms is 8 cycles so a 624-word count fits inside the 130 ms default limit
  localparam int MSC = 8;
  logic aclk;
  logic aresetn = 1'b0;
  sxu_axi_req_s axi_req;
  sxu_axi_rsp_s axi_rsp;
  logic error_flag, equal_flag, cpu_halt, severe_fault;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [1:0] resp;
  logic [31:0] rdv;
  sxu_special_exec #(.MEM_WORDS(2048), .AREA_WORDS(1024), .MS_CYCLES(MSC)) sxu_special_exec_i (.aclk(aclk),
    .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp), .error_flag(error_flag), .equal_flag(equal_flag),
    .cpu_halt(cpu_halt), .severe_fault(severe_fault));
  sxu_seq_model sxu_seq_model_i (.aclk(aclk), .axi_req(axi_req), .axi_rsp(axi_rsp));
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    sxu_seq_model_i.wr(a, d, resp);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    sxu_seq_model_i.rd(a, rdv, resp);
  endtask : rd
  task automatic mem_wr(input int a, input logic [15:0] d);
    wr(OFS_MEM_ADDR, 32'(a));
    wr(OFS_MEM_DATA, {16'h0000, d});
    wr(OFS_CMD, 32'h10); // Scan mark, else long setups trip the watchdog
  endtask : mem_wr
  task automatic mem_chk(input string nm, input int a, input logic [15:0] e);
    wr(OFS_MEM_ADDR, 32'(a));
    rd(OFS_MEM_DATA);
    chk(nm, {16'h0000, e}, rdv);
  endtask : mem_chk
  task automatic flags(input string nm, input logic e, input logic q);
    chk({nm, " error"}, {31'h0, e}, {31'h0, error_flag});
    chk({nm, " equal"}, {31'h0, q}, {31'h0, equal_flag});
  endtask : flags
  task automatic run(input logic [31:0] cmd, a, input int b, c);
    int n;
    wr(OFS_OPA, a);
    wr(OFS_OPB, 32'(b));
    wr(OFS_OPC, 32'(c));
    wr(OFS_CMD, cmd | 32'h10); // Scan mark keeps each run inside the default limit
    n = 0;
    rdv = 32'h1;
    while (rdv[ST_BUSY_BIT] !== 1'b0 && n < 2000) begin
      rd(OFS_STATUS);
      n++;
    end
    chk("engine idle", 32'h0, {31'h0, rdv[ST_BUSY_BIT]});
  endtask : run
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_bus();
    rd(OFS_WD_LIMIT);
    chk("reset limit", 32'h82, rdv);
    flags("reset", 1'b0, 1'b0);
    rd(8'h40);
    chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
    wr(OFS_MEM_ADDR, 32'd2048);
    wr(OFS_MEM_DATA, 32'h1);
    chk("overrun resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
  endtask : t_bus
  task automatic t_bitcount();
    logic [31:0] ea [5] = '{32'h20000, 32'h2001a, 32'h20003, 32'h102bf, 32'h102c0};
    int sb [5] = '{701, 701, 1022, 701, 701};
    for (int i = 0; i < 625; i++) mem_wr(i, 16'hffff);
    mem_wr(700, 16'h0000);
    mem_wr(701, 16'h8001);
    mem_wr(702, 16'h0f0f);
    mem_wr(703, 16'h00a0);
    mem_wr(704, 16'h2048);
    run(32'h1c, 32'h20624, 0, 710);
    mem_chk("total 624 words", 710, 16'h9984);
    flags("total 624", 1'b0, 1'b0);
    run(32'h1c, 32'h20625, 0, 710);
    flags("total 625", 1'b1, 1'b0);
    mem_chk("dest after overflow", 710, 16'h9984);
    run(32'h18, 32'h20002, 701, 710);
    mem_chk("dest when skipped", 710, 16'h9984);
    flags("skipped", 1'b1, 1'b0);
    run(32'h1c, 32'h20002, 701, 711);
    mem_chk("two words", 711, 16'h0010);
    rd(OFS_RESULT);
    chk("result register", 32'h10, rdv);
    run(32'h1c, 32'h20001, 700, 712);
    flags("zero total", 1'b0, 1'b1);
    for (int i = 0; i < 5; i++) begin
      run(32'h1c, 32'h20001, 701, 713);
      flags("good count", 1'b0, 1'b0);
      run(32'h1c, ea[i], sb[i], 713);
      flags("bad count", 1'b1, 1'b0);
    end
  endtask : t_bitcount
  task automatic t_trig();
    logic [15:0] sel [5] = '{16'h0, 16'h1, 16'h0, 16'h1, 16'h0};
    logic [15:0] ang [5] = '{16'h0300, 16'h0900, 16'h0900, 16'h0300, 16'h0901};
    logic [15:0] ex [5] = '{16'h5000, 16'h0000, 16'h9999, 16'h8660, 16'h1111};
    for (int i = 0; i < 5; i++) begin
      mem_wr(720, ang[i]); // Angle kept within 0 to 900 except the last, refused, case
      run(32'h1d, {14'h0, 2'b10, sel[i]}, 720, 721);
      flags("trig", i == 4, ex[i] == 16'h0);
      if (i < 4) mem_chk("trig result", 721, ex[i]);
    end
  endtask : t_trig
  task automatic t_table();
    logic [15:0] hdr [3] = '{16'hc001, 16'h4001, 16'h8001};
    logic [15:0] xin [3] = '{16'h0005, 16'h0015, 16'h000f};
    logic [15:0] ex [3] = '{16'h00c8, 16'h015e, 16'h0350};
    for (int i = 0; i < 6; i++) mem_wr(801 + i, i[0] ? 16'(100 * i - 100 * (i / 5)) : 16'(5 * i));
    for (int i = 0; i < 3; i++) begin
      mem_wr(800, hdr[i]);
      mem_wr(730, xin[i]);
      run(32'h1d, 32'd800, 730, 731);
      mem_chk("table result", 731, ex[i]);
      flags("table", 1'b0, 1'b0);
    end
    mem_wr(1020, 16'hc001);
    run(32'h1d, 32'd1020, 730, 731);
    flags("table across boundary", 1'b1, 1'b0);
  endtask : t_table
  task automatic t_watchdog();
    int n;
    wr(OFS_CMD, 32'h10);
    run(32'h0e, 32'h0, 0, 32'h2003f);
    rd(OFS_WD_LIMIT);
    chk("limit at 63", 32'h191e, rdv);
    flags("after extend", 1'b1, 1'b0);
    wr(OFS_CMD, 32'h10);
    run(32'h0e, 32'h0, 0, 32'h20040);
    run(32'h0e, 32'h0, 0, 32'h20001);
    rd(OFS_WD_LIMIT);
    chk("limit at 1", 32'he6, rdv);
    repeat (1400) @(posedge aclk);
    chk("halt at 175 ms", 32'h0, {31'h0, cpu_halt});
    n = 0;
    while (cpu_halt !== 1'b1 && n < 1000) begin
      @(posedge aclk);
      n++;
    end
    chk("halt", 32'h1, {31'h0, cpu_halt});
    chk("severe early", 32'h0, {31'h0, severe_fault});
    rd(OFS_FAULT);
    chk("fault code", {24'h0, FAULT_WD}, rdv);
    repeat (51000) @(posedge aclk);
    chk("severe", 32'h1, {31'h0, severe_fault});
  endtask : t_watchdog
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      n_fail++;
      report_and_stop();
    end
  end
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_bus();
    t_bitcount();
    t_trig();
    t_table();
    t_watchdog();
    report_and_stop();
  end
endmodule : special_instr_exec_unit_tb_top
`default_nettype wire

//--- sxu_pkg.sv
package sxu_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_OPA = 8'h04;
  localparam logic [7:0] OFS_OPB = 8'h08;
  localparam logic [7:0] OFS_OPC = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_RESULT = 8'h14;
  localparam logic [7:0] OFS_FAULT = 8'h18;
  localparam logic [7:0] OFS_MEM_ADDR = 8'h1c;
  localparam logic [7:0] OFS_MEM_DATA = 8'h20;
  localparam logic [7:0] OFS_WD_LIMIT = 8'h24;
  // Command fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_EXEC_BIT = 2;
  localparam int CMD_GO_BIT = 3;
  localparam int CMD_SCAN_BIT = 4;
  localparam logic [1:0] OP_BITCOUNT = 2'h0;
  localparam logic [1:0] OP_VALCALC = 2'h1;
  localparam logic [1:0] OP_WDEXT = 2'h2;
  // Operand fields
  localparam int OPND_IND_BIT = 16;
  localparam int OPND_IMM_BIT = 17;
  // Status fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_ERR_BIT = 1;
  localparam int ST_EQ_BIT = 2;
  localparam int ST_HALT_BIT = 3;
  localparam int ST_SEVERE_BIT = 4;
  // Table header and function select
  localparam int HDR_OUT_BIN_BIT = 14;
  localparam int HDR_IN_BIN_BIT = 15;
  localparam logic [15:0] SEL_SINE = 16'h0000;
  localparam logic [15:0] SEL_COSINE = 16'h0001;
  localparam logic [15:0] ANGLE_MAX_BCD = 16'h0900;
  localparam logic [9:0] ANGLE_MAX_TENTHS = 10'h384;
  localparam logic [17:0] DEC_MAX = 18'h0270f;
  localparam logic [7:0] FAULT_WD = 8'h9f;
  // Sine at 0,10..90 degrees, scaled by 10000
  localparam logic [9:0][13:0] SIN_TAB = {14'h2710, 14'h2678, 14'h24b5, 14'h21d4, 14'h1dec, 14'h191c,
                                          14'h1388, 14'h0d5c, 14'h06c8, 14'h0000};
  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
  localparam logic [12:0] WD_DEFAULT_MS = 13'h0082;
  localparam logic [12:0] WD_STEP_MS = 13'h0064;
  localparam logic [12:0] WD_ABS_MS = 13'h1964;
  localparam logic [15:0] WD_EXT_MAX = 16'h003f;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } sxu_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sxu_axi_rsp_s;

  typedef enum logic [1:0] {ST_IDLE, ST_COUNT, ST_SEG, ST_FINISH} sxu_fsm_e;

  typedef struct packed {
    sxu_axi_rsp_s rsp;
    logic aw_have;
    logic w_have;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [4:0] cmd;
    logic [17:0] opa;
    logic [17:0] opb;
    logic [17:0] opc;
    logic [15:0] mem_addr;
    sxu_fsm_e fsm;
    logic error_flag;
    logic equal_flag;
    logic halt;
    logic severe;
    logic [7:0] fault_code;
    logic [15:0] result;
    logic [15:0] ptr;
    logic [15:0] left;
    logic [15:0] dest;
    logic [17:0] acc;
    logic out_bin;
    logic [15:0] xin;
    logic [7:0] seg_idx;
    logic [7:0] seg_last;
    logic [15:0] px;
    logic [15:0] py;
    logic [31:0] ms_div;
    logic [12:0] scan_ms;
    logic [12:0] wd_limit_ms;
  } sxu_state_s;

  localparam sxu_state_s STATE_RST = '{rsp: '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0},
                                       fsm: ST_IDLE, wd_limit_ms: WD_DEFAULT_MS, default: '0};
endpackage : sxu_pkg

//--- sxu_seq_model.sv
`timescale 1ns/1ns
`default_nettype none
module sxu_seq_model
  import sxu_pkg::*;
(
  input wire logic aclk,
  output var sxu_axi_req_s axi_req,
  input wire sxu_axi_rsp_s axi_rsp
);
  initial axi_req = '0;
  ////////////////////////////////////////////////////////////////////////////////
  // Each channel is held until its own ready edge; no answer time is assumed
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    axi_req.awaddr <= a;
    axi_req.awvalid <= 1'b1;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hf;
    axi_req.wvalid <= 1'b1;
    axi_req.bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
      if (axi_req.bready && axi_rsp.bvalid) begin
        r = axi_rsp.bresp;
        axi_req.bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    axi_req.araddr <= a;
    axi_req.arvalid <= 1'b1;
    axi_req.rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'b0;
      if (axi_req.rready && axi_rsp.rvalid) begin
        d = axi_rsp.rdata;
        r = axi_rsp.rresp;
        axi_req.rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : rd
endmodule : sxu_seq_model
`default_nettype wire

//--- sxu_special_exec.sv
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Execution condition off: bit count does nothing
// - Count set bits over N words, store total
// - Error on non-BCD or zero count, area crossing
// - Error when bit total exceeds 9999
// - Equal flag set when written result is zero
// - Control operand picks sine, cosine or table
// - Error when angle exceeds ninety degrees
// - Trig result four fraction digits, truncated, 0.9999
// - Error when approximation table is unreadable
// - Error on bad indirect pointer or overrun
// - Header: segments minus one, format bits 14/15
// - Watchdog limit extended by 100 ms times operand
// - Cycle over limit: fault code out, halt
// - Cycle over 6500 ms: severe fault, stop
// - Watchdog extension leaves flags unchanged
module sxu_special_exec
  import sxu_pkg::*;
#(
  parameter int MEM_WORDS = 256,
  parameter int AREA_WORDS = 128,
  parameter int MS_CYCLES = MS_CYCLES_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire sxu_axi_req_s axi_req,
  output var sxu_axi_rsp_s axi_rsp,
  output logic error_flag,
  output logic equal_flag,
  output logic cpu_halt,
  output logic severe_fault
);
  ////////////////////////////////////////////////////////////////////////////
  if (MEM_WORDS < 2 || MEM_WORDS > 65536 || AREA_WORDS < 1 || MEM_WORDS % AREA_WORDS != 0 ||
      MS_CYCLES < 1) begin : g_bad_param
    $error("sxu_special_exec: memory sizing or prescaler not supported");
  end
  localparam int MAW = (MEM_WORDS > 2) ? $clog2(MEM_WORDS) : 1;
  localparam logic [16:0] MEM_LIM = 17'(MEM_WORDS);
  localparam logic [16:0] AREA_SZ = 17'(AREA_WORDS);
  logic [15:0] mem [MEM_WORDS];
  sxu_state_s st;
  sxu_state_s n;
  logic mem_we;
  logic [MAW-1:0] mem_wa;
  logic [15:0] mem_wd;
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic in_mem(input logic [16:0] a);
    return a < MEM_LIM;
  endfunction : in_mem
  function automatic logic [15:0] mem_rd(input logic [16:0] a);
    return in_mem(a) ? mem[a[MAW-1:0]] : 16'h0000;
  endfunction : mem_rd
  function automatic logic same_area(input logic [16:0] a, input logic [16:0] b);
    return (a / AREA_SZ) == (b / AREA_SZ);
  endfunction : same_area
  function automatic logic is_bcd(input logic [15:0] v);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (v[i*4+:4] > 4'h9) ok = 1'b0;
    end
    return ok;
  endfunction : is_bcd
  function automatic logic [15:0] bcd2bin(input logic [15:0] v);
    return 16'(v[15:12]) * 16'h03e8 + 16'(v[11:8]) * 16'h0064 + 16'(v[7:4]) * 16'h000a + 16'(v[3:0]);
  endfunction : bcd2bin
  function automatic logic [15:0] bin2bcd(input logic [17:0] v);
    logic [17:0] r;
    logic [15:0] o;
    r = v;
    o = 16'h0000;
    for (int i = 0; i < 4; i++) begin
      o[i*4+:4] = 4'(r % 18'h0000a);
      r = 18'(r / 18'h0000a);
    end
    return o;
  endfunction : bin2bcd
  function automatic logic [4:0] popcount(input logic [15:0] v);
    logic [4:0] c;
    c = 5'h00;
    for (int i = 0; i < 16; i++) begin
      c = c + 5'(v[i]);
    end
    return c;
  endfunction : popcount
  // Returns {error, word address}; indirect pointers must be BCD and stay inside memory
  function automatic logic [16:0] resolve(input logic [17:0] op);
    logic [15:0] pw;
    logic [15:0] a;
    pw = mem_rd({1'b0, op[15:0]});
    a = bcd2bin(pw);
    if (!op[OPND_IND_BIT]) return {!in_mem({1'b0, op[15:0]}), op[15:0]};
    if (!in_mem({1'b0, op[15:0]}) || !is_bcd(pw) || !in_mem({1'b0, a})) return {1'b1, 16'h0000};
    return {1'b0, a};
  endfunction : resolve
  // Tenths of a degree in, sine scaled by 10000 out; linear between 10 degree points
  function automatic logic [17:0] sine(input logic [9:0] a);
    logic [3:0] idx;
    logic [17:0] fr;
    logic [17:0] lo;
    logic [17:0] hi;
    logic [17:0] v;
    idx = 4'(a / 10'h064);
    fr = 18'(a % 10'h064);
    lo = 18'(SIN_TAB[idx]);
    hi = (idx == 4'h9) ? lo : 18'(SIN_TAB[idx + 4'h1]);
    v = lo + 18'(((hi - lo) * fr) / 18'h00064);
    return (v > DEC_MAX) ? DEC_MAX : v;
  endfunction : sine
  function automatic logic [17:0] interp(input logic [15:0] x0, input logic [15:0] y0, input logic [15:0] x1,
                                         input logic [15:0] y1, input logic [15:0] x);
    logic [31:0] num;
    logic [15:0] d;
    num = 32'(x - x0) * 32'((y1 >= y0) ? (y1 - y0) : (y0 - y1));
    d = 16'(num / 32'(x1 - x0));
    return (y1 >= y0) ? 18'(y0 + d) : 18'(y0 - d);
  endfunction : interp
  function automatic logic xin_le_xi(input logic [15:0] x, input logic [15:0] p);
    return x <= p;
  endfunction : xin_le_xi
  ////////////////////////////////////////////////////////////////////////////
  logic go;
  logic busy;
  logic [16:0] ra;
  logic [16:0] rb;
  logic [16:0] rc;
  logic [15:0] nval;
  logic [16:0] span_end;
  logic [16:0] tab_end;
  logic [15:0] hdr;
  logic [15:0] xraw;
  logic [15:0] xi;
  logic [15:0] yi;
  logic [8:0] segs;
  logic [9:0] ang;
  always_comb begin
    n = st;
    go = 1'b0;
    busy = st.fsm != ST_IDLE;
    mem_we = 1'b0;
    mem_wa = '0;
    mem_wd = 16'h0000;
    ra = resolve(st.opa);
    rb = resolve(st.opb);
    rc = resolve(st.opc);
    nval = st.opa[OPND_IMM_BIT] ? st.opa[15:0] : mem_rd({1'b0, ra[15:0]});
    span_end = {1'b0, rb[15:0]} + 17'(bcd2bin(nval)) - 17'h00001;
    hdr = mem_rd({1'b0, ra[15:0]});
    segs = 9'(hdr[7:0]) + 9'h001;
    tab_end = {1'b0, ra[15:0]} + 17'({segs, 1'b0}) + 17'h00002;
    xraw = mem_rd({1'b0, rb[15:0]});
    ang = 10'(bcd2bin(xraw));
    xi = mem_rd({1'b0, st.ptr});
    yi = mem_rd({1'b0, st.ptr} + 17'h00001);
    // AXI4-Lite write side: address and data taken in either order
    if (st.rsp.bvalid && axi_req.bready) n.rsp.bvalid = 1'b0;
    if (st.rsp.awready && axi_req.awvalid) begin
      n.aw_have = 1'b1;
      n.waddr = axi_req.awaddr;
      n.rsp.awready = 1'b0;
    end
    if (st.rsp.wready && axi_req.wvalid) begin
      n.w_have = 1'b1;
      n.wdata = axi_req.wdata;
      n.wstrb = axi_req.wstrb;
      n.rsp.wready = 1'b0;
    end
    if (st.aw_have && st.w_have && !st.rsp.bvalid) begin
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
      n.rsp.awready = 1'b1;
      n.rsp.wready = 1'b1;
      n.rsp.bvalid = 1'b1;
      n.rsp.bresp = RESP_OKAY;
      unique case (st.waddr)
        OFS_CMD: begin
          if (st.wstrb[0]) begin
            n.cmd = st.wdata[4:0];
            go = st.wdata[CMD_GO_BIT] && !busy && !st.halt;
            if (st.wdata[CMD_SCAN_BIT]) begin
              n.scan_ms = 13'h0000;
              n.ms_div = 32'h0;
              n.wd_limit_ms = WD_DEFAULT_MS;
            end
          end
        end
        OFS_OPA: n.opa = st.wdata[17:0];
        OFS_OPB: n.opb = st.wdata[17:0];
        OFS_OPC: n.opc = st.wdata[17:0];
        OFS_MEM_ADDR: n.mem_addr = st.wdata[15:0];
        OFS_MEM_DATA: begin
          // Memory port belongs to the engine while it runs
          if (busy || !in_mem({1'b0, st.mem_addr})) begin
            n.rsp.bresp = RESP_SLVERR;
          end else begin
            mem_we = 1'b1;
            mem_wa = st.mem_addr[MAW-1:0];
            mem_wd = st.wdata[15:0];
          end
        end
        default: n.rsp.bresp = RESP_SLVERR;
      endcase
    end
    // AXI4-Lite read side
    if (st.rsp.rvalid && axi_req.rready) begin
      n.rsp.rvalid = 1'b0;
      n.rsp.arready = 1'b1;
    end
    if (st.rsp.arready && axi_req.arvalid) begin
      n.rsp.arready = 1'b0;
      n.rsp.rvalid = 1'b1;
      n.rsp.rresp = RESP_OKAY;
      unique case (axi_req.araddr)
        OFS_CMD: n.rsp.rdata = 32'(st.cmd);
        OFS_OPA: n.rsp.rdata = 32'(st.opa);
        OFS_OPB: n.rsp.rdata = 32'(st.opb);
        OFS_OPC: n.rsp.rdata = 32'(st.opc);
        OFS_STATUS: n.rsp.rdata = 32'({st.severe, st.halt, st.equal_flag, st.error_flag, busy});
        OFS_RESULT: n.rsp.rdata = 32'(st.result);
        OFS_FAULT: n.rsp.rdata = 32'(st.fault_code);
        OFS_MEM_ADDR: n.rsp.rdata = 32'(st.mem_addr);
        OFS_MEM_DATA: n.rsp.rdata = 32'(mem_rd({1'b0, st.mem_addr}));
        OFS_WD_LIMIT: n.rsp.rdata = 32'(st.wd_limit_ms);
        default: begin
          n.rsp.rdata = 32'h0;
          n.rsp.rresp = RESP_SLVERR;
        end
      endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    unique case (st.fsm)
      ST_IDLE: begin
        // The command being written decides, not the one stored before it
        if (go && n.cmd[CMD_EXEC_BIT]) begin
          unique case (n.cmd[CMD_OP_LSB+:2])
            OP_BITCOUNT: begin
              if ((!st.opa[OPND_IMM_BIT] && ra[16]) || rb[16] || rc[16] || !is_bcd(nval) ||
                  nval == 16'h0000 || !in_mem(span_end) || !same_area({1'b0, rb[15:0]}, span_end)) begin
                n.error_flag = 1'b1;
              end else begin
                n.ptr = rb[15:0];
                n.left = bcd2bin(nval);
                n.dest = rc[15:0];
                n.acc = 18'h00000;
                n.out_bin = 1'b0;
                n.fsm = ST_COUNT;
              end
            end
            OP_VALCALC: begin
              n.dest = rc[15:0];
              if (rb[16] || rc[16]) begin
                n.error_flag = 1'b1;
              end else if (st.opa[OPND_IMM_BIT]) begin
                // Immediate control selects a trig function
                if ((st.opa[15:0] != SEL_SINE && st.opa[15:0] != SEL_COSINE) || !is_bcd(xraw) ||
                    xraw > ANGLE_MAX_BCD) begin
                  n.error_flag = 1'b1;
                end else begin
                  n.acc = sine(st.opa[15:0] == SEL_COSINE ? ANGLE_MAX_TENTHS - ang : ang);
                  n.out_bin = 1'b0;
                  n.fsm = ST_FINISH;
                end
              end else if (ra[16] || !in_mem(tab_end) || !same_area({1'b0, ra[15:0]}, tab_end) ||
                           (!hdr[HDR_IN_BIN_BIT] && !is_bcd(xraw))) begin
                n.error_flag = 1'b1;
              end else begin
                n.xin = hdr[HDR_IN_BIN_BIT] ? xraw : bcd2bin(xraw);
                n.out_bin = hdr[HDR_OUT_BIN_BIT];
                n.ptr = ra[15:0] + 16'h0001;
                n.seg_idx = 8'h00;
                n.seg_last = segs[7:0];
                n.fsm = ST_SEG;
              end
            end
            OP_WDEXT: begin
              // Flags untouched; out-of-range operand is ignored
              if (st.opc[15:0] <= WD_EXT_MAX) begin
                n.wd_limit_ms = WD_DEFAULT_MS + 13'(WD_STEP_MS * 13'(st.opc[5:0]));
              end
            end
            default: ;
          endcase
        end
      end
      ST_COUNT: begin
        n.acc = st.acc + 18'(popcount(mem_rd({1'b0, st.ptr})));
        n.ptr = st.ptr + 16'h0001;
        n.left = st.left - 16'h0001;
        if (st.left == 16'h0001) n.fsm = ST_FINISH;
      end
      ST_SEG: begin
        // Walk end-points until the input is not beyond the current x
        if (xin_le_xi(st.xin, xi) || st.seg_idx == st.seg_last) begin
          if (st.seg_idx == 8'h00 || !xin_le_xi(st.xin, xi)) begin
            n.acc = 18'(yi);
          end else begin
            n.acc = interp(st.px, st.py, xi, yi, st.xin);
          end
          n.fsm = ST_FINISH;
        end else begin
          n.px = xi;
          n.py = yi;
          n.ptr = st.ptr + 16'h0002;
          n.seg_idx = st.seg_idx + 8'h01;
        end
      end
      ST_FINISH: begin
        n.fsm = ST_IDLE;
        if (!st.out_bin && st.acc > DEC_MAX) begin
          n.error_flag = 1'b1;
        end else begin
          mem_we = 1'b1;
          mem_wa = st.dest[MAW-1:0];
          mem_wd = st.out_bin ? st.acc[15:0] : bin2bcd(st.acc);
          n.result = mem_wd;
          n.error_flag = 1'b0;
          n.equal_flag = st.acc == 18'h00000;
        end
      end
    endcase
    ////////////////////////////////////////////////////////////////////////////
    // Scan-time watchdog; millisecond prescaler is a parameter so benches can shrink it
    if (n.ms_div == 32'(MS_CYCLES - 1)) begin
      n.ms_div = 32'h0;
      if (n.scan_ms != '1) n.scan_ms = n.scan_ms + 13'h0001;
    end else begin
      n.ms_div = n.ms_div + 32'h1;
    end
    if (st.scan_ms > st.wd_limit_ms) begin
      n.halt = 1'b1;
      n.fault_code = FAULT_WD;
    end
    if (st.scan_ms > WD_ABS_MS) begin
      n.severe = 1'b1;
      n.halt = 1'b1;
      n.fault_code = FAULT_WD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= STATE_RST;
    end else begin
      st <= n;
    end
  end
  // Data words carry no reset; software loads them before use
  always_ff @(posedge aclk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end
  assign axi_rsp = st.rsp;
  assign error_flag = st.error_flag;
  assign equal_flag = st.equal_flag;
  assign cpu_halt = st.halt;
  assign severe_fault = st.severe;
endmodule : sxu_special_exec
`default_nettype wire

//--- sxu_special_exec_props.sv
`timescale 1ns/1ns
`default_nettype none
module sxu_special_exec_props
  import sxu_pkg::*;
#(
  parameter int MEM_WORDS = 256,
  parameter int AREA_WORDS = 128,
  parameter int MS_CYCLES = MS_CYCLES_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire sxu_axi_req_s axi_req,
  input wire sxu_axi_rsp_s axi_rsp,
  input wire logic error_flag,
  input wire logic equal_flag,
  input wire logic cpu_halt,
  input wire logic severe_fault
);
  localparam int HALT_MIN = 130 * MS_CYCLES;
  localparam int SEV_MIN = 6500 * MS_CYCLES;
  int quiet_cnt;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  // Cycles since the last scan mark seen as one command beat; a split beat is missed, so it only overcounts
  always_ff @(posedge aclk) begin
    if (!aresetn || (axi_req.awvalid && axi_rsp.awready && axi_req.awaddr == OFS_CMD && axi_req.wvalid &&
        axi_rsp.wready && axi_req.wstrb[0] && axi_req.wdata[CMD_SCAN_BIT])) quiet_cnt <= 0;
    else quiet_cnt <= quiet_cnt + 1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_bvalid_holds: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write response dropped before bready");
  a_rvalid_holds: assert property (axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read data dropped before rready");
  a_read_answer: assert property (axi_req.arvalid && axi_rsp.arready |=> !axi_rsp.arready && axi_rsp.rvalid)
    else $error("read not answered one cycle after address");
  a_write_answer: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
    |=> !axi_rsp.awready ##1 axi_rsp.bvalid) else $error("write response not two cycles after address");
  a_halt_sticky: assert property (cpu_halt |=> cpu_halt)
    else $error("halt released without reset");
  a_severe_sticky: assert property (severe_fault |=> severe_fault)
    else $error("severe fault released without reset");
  a_halt_not_early: assert property ($rose(cpu_halt) |-> quiet_cnt >= HALT_MIN)
    else $error("halt before the default limit ran out");
  a_severe_late: assert property ($rose(severe_fault) |-> cpu_halt && quiet_cnt >= SEV_MIN)
    else $error("severe fault before the absolute limit");
  c_write: cover property (axi_rsp.bvalid && axi_req.bready);
  c_read: cover property (axi_rsp.rvalid && axi_req.rready);
  c_error: cover property ($rose(error_flag));
  c_severe: cover property ($rose(severe_fault));
endmodule : sxu_special_exec_props
bind sxu_special_exec sxu_special_exec_props #(.MEM_WORDS(MEM_WORDS), .AREA_WORDS(AREA_WORDS),
  .MS_CYCLES(MS_CYCLES)) sxu_special_exec_props_i (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req),
  .axi_rsp(axi_rsp), .error_flag(error_flag), .equal_flag(equal_flag), .cpu_halt(cpu_halt),
  .severe_fault(severe_fault));
`default_nettype wire
